// ==== core/dacc_bank.sv ====
// Purpose: Mode and conversion value registers of the converter
// Assumes: Write strobes already decoded by the top
// Notes: Contents are cleared while the converter clock is gated off
`timescale 1ns/1ns
`include "dacc_params.svh"
module dacc_bank
   import dacc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic wr_mode_i,
   input wire logic wr_value_i,
   input wire dacc_byte_type wdata_i,
   dacc_conv_if.bank cif
);
   dacc_byte_type mode_r;
   dacc_byte_type mode_nxt;
   dacc_byte_type value_r;
   dacc_byte_type value_nxt;

   // Gate-off clears and blocks writes, so no stale setting survives a re-enable
   always_comb
   begin
      mode_nxt = mode_r;
      value_nxt = value_r;
      if (!cif.conv_clk_en)
      begin
         mode_nxt = `DACC_RST_MODE; // R3 R2
         value_nxt = `DACC_RST_VALUE; // R3 R2
      end
      else
      begin
         if (wr_mode_i)
            mode_nxt = wdata_i & `DACC_MODE_MASK; // R4
         if (wr_value_i)
            value_nxt = wdata_i; // R4
      end
   end

   // Register stage
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_r <= `DACC_RST_MODE;
         value_r <= `DACC_RST_VALUE;
      end
      else
      begin
         mode_r <= mode_nxt;
         value_r <= value_nxt;
      end
   end

   assign cif.mode = mode_r;
   assign cif.value = value_r;
endmodule

// ==== core/dacc_out.sv ====
// Purpose: Output stage that hands the conversion code to the analogue core
// Assumes: Real-time trigger comes from timer logic on the same clock
// Notes: Code reads as zero whenever conversion is stopped
`timescale 1ns/1ns
`include "dacc_params.svh"
module dacc_out
   import dacc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic rt_trigger_i,
   dacc_conv_if.conv cif,
   output dacc_byte_type code_o,
   output logic active_o
);
   dacc_mode_type mode_sel;
   dacc_byte_type code_r;
   dacc_byte_type code_nxt;
   logic active_r;
   logic active_nxt;

   assign mode_sel = cif.mode[`DACC_BIT_MODE0] ? DACC_REALTIME : DACC_NORMAL; // R5

   // Code update: normal follows the register, real-time waits for the trigger
   always_comb
   begin
      active_nxt = cif.conv_clk_en & cif.mode[`DACC_BIT_CONV0]; // R6
      code_nxt = code_r;
      if (!active_nxt)
         code_nxt = `DACC_RST_CODE; // R6 R3
      else
      begin
         case (mode_sel)
            DACC_NORMAL: code_nxt = cif.value; // R9 R7
            DACC_REALTIME:
            begin
               if (rt_trigger_i)
                  code_nxt = cif.value; // R5
            end
            default: code_nxt = `DACC_RST_CODE;
         endcase
      end
   end

   // Register stage
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         code_r <= `DACC_RST_CODE;
         active_r <= 1'b0;
      end
      else
      begin
         code_r <= code_nxt;
         active_r <= active_nxt;
      end
   end

   assign code_o = code_r;
   assign active_o = active_r;
endmodule

// ==== core/dacc_top.sv ====
// Purpose: Control of one 8-bit converter channel: clock gate, registers, pin
// Assumes: Register strobes are one cycle, never together, on mclk_i
// Notes: The code output drives an analogue core whose output is ref * code / 256
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "dacc_params.svh"
module dacc_top
   import dacc_pkg::*;
#(
   parameter int ADDR_W = 3
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire dacc_byte_type reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output dacc_byte_type reg_rdata_o,
   input wire logic rt_trigger_i,
   output logic conv_clk_en_o,
   output logic conv_active_o,
   output logic realtime_mode_o,
   output dacc_byte_type analog_code_o,
   output dacc_byte_type port2_out_en_o,
   output logic analog_out_buf_en_o
);
   dacc_conv_if cif ();

   dacc_byte_type pce_r;
   dacc_byte_type pce_nxt;
   dacc_byte_type pdir_r;
   dacc_byte_type pdir_nxt;
   dacc_byte_type rdata_r;
   dacc_byte_type rdata_nxt;
   logic [2:0] addr_lo;
   logic addr_hi_zero;
   logic sel_pce;
   logic sel_mode;
   logic sel_value;
   logic sel_pdir;
   logic wr_mode;
   logic wr_value;

   // Address decode; upper address bits must be zero for any hit
   assign addr_lo = reg_addr_i[2:0];
   assign addr_hi_zero = (reg_addr_i >> 3) == '0;
   assign sel_pce = addr_hi_zero && (addr_lo == `DACC_OFS_PCE);
   assign sel_mode = addr_hi_zero && (addr_lo == `DACC_OFS_MODE);
   assign sel_value = addr_hi_zero && (addr_lo == `DACC_OFS_VALUE);
   assign sel_pdir = addr_hi_zero && (addr_lo == `DACC_OFS_PDIR);

   // Converter writes pass only while its clock runs; the bank also blocks them
   assign wr_mode = reg_wr_i && sel_mode && pce_r[`DACC_BIT_CLKEN]; // R2 R4
   assign wr_value = reg_wr_i && sel_value && pce_r[`DACC_BIT_CLKEN]; // R2 R4

   // Enable and port direction registers sit outside the converter, always writable
   always_comb
   begin
      pce_nxt = pce_r;
      pdir_nxt = pdir_r;
      if (reg_wr_i && sel_pce)
         pce_nxt = reg_wdata_i & `DACC_PCE_MASK;
      if (reg_wr_i && sel_pdir)
         pdir_nxt = reg_wdata_i;
   end

   // Read data stand for exactly one cycle after the strobe, else zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (reg_rd_i)
      begin
         if (sel_pce)
            rdata_nxt = pce_r;
         else if (sel_mode)
            rdata_nxt = pce_r[`DACC_BIT_CLKEN] ? cif.mode : `DACC_RST_MODE; // R4
         else if (sel_value)
            rdata_nxt = pce_r[`DACC_BIT_CLKEN] ? cif.value : `DACC_RST_VALUE; // R4
         else if (sel_pdir)
            rdata_nxt = pdir_r;
      end
   end

   // Register stage
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pce_r <= `DACC_RST_PCE;
         pdir_r <= `DACC_RST_PDIR;
         rdata_r <= 8'h00;
      end
      else
      begin
         pce_r <= pce_nxt;
         pdir_r <= pdir_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Clock gate level; a glitch-free cell downstream uses it, no clock is made here
   assign cif.conv_clk_en = pce_r[`DACC_BIT_CLKEN]; // R1 R3

   dacc_bank u_bank (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .wr_mode_i(wr_mode),
      .wr_value_i(wr_value),
      .wdata_i(reg_wdata_i),
      .cif(cif.bank)
   );

   dacc_out u_out (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .rt_trigger_i(rt_trigger_i),
      .cif(cif.conv),
      .code_o(analog_code_o),
      .active_o(conv_active_o)
   );

   // Outputs; a set direction bit turns the digital driver off
   assign reg_rdata_o = rdata_r;
   assign conv_clk_en_o = pce_r[`DACC_BIT_CLKEN]; // R1
   assign realtime_mode_o = cif.mode[`DACC_BIT_MODE0]; // R5
   assign port2_out_en_o = ~pdir_r; // R8
   assign analog_out_buf_en_o = ~pdir_r[`DACC_BIT_PINDIR]; // R8

   // Checks on the block's own behaviour
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   sequence wr_val_s;
      reg_wr_i && sel_value && conv_clk_en_o;
   endsequence

   clock_gate_a: // R1
      assert property (reg_wr_i && sel_pce |=> conv_clk_en_o == $past(reg_wdata_i[7]))
      else $error("Converter clock enable does not follow the written bit");

   write_block_a: // R2
      assert property (!conv_clk_en_o && reg_wr_i && (sel_value || sel_mode)
                       |=> cif.value == `DACC_RST_VALUE && cif.mode == `DACC_RST_MODE)
      else $error("Converter register took a write while its clock was off");

   held_reset_a: // R3
      assert property (!conv_clk_en_o [*2] |-> analog_code_o == `DACC_RST_CODE
                       && !conv_active_o && !realtime_mode_o)
      else $error("Converter not held in reset while its clock was off");

   write_take_a: // R4
      assert property (wr_val_s |=> cif.value == $past(reg_wdata_i))
      else $error("Conversion value write lost while clock enabled");

   read_back_a: // R4
      assert property (reg_rd_i && sel_mode && conv_clk_en_o
                       |=> reg_rdata_o == $past(cif.mode)
                       ##1 (reg_rdata_o == 8'h00 || $past(reg_rd_i)))
      else $error("Mode read back wrong or read data held too long");

   rt_hold_a: // R5
      assert property (conv_clk_en_o && realtime_mode_o && cif.mode[`DACC_BIT_CONV0]
                       && !rt_trigger_i && conv_active_o
                       |=> analog_code_o == $past(analog_code_o))
      else $error("Real-time mode code changed without a trigger");

   stop_zero_a: // R6
      assert property (conv_clk_en_o && !cif.mode[`DACC_BIT_CONV0]
                       |=> !conv_active_o && analog_code_o == `DACC_RST_CODE)
      else $error("Conversion did not stop when disabled");

   normal_follow_a: // R9
      assert property (wr_val_s ##1 (conv_clk_en_o && !realtime_mode_o
                       && cif.mode[`DACC_BIT_CONV0]) |=> analog_code_o == $past(cif.value))
      else $error("Normal mode did not present the new code");

   code_range_a: // R7
      assert property ({1'b0, analog_code_o} < `DACC_CODE_STEPS
                       && (conv_active_o || analog_code_o == `DACC_RST_CODE))
      else $error("Output code out of range or present while stopped");

   pin_buf_a: // R8
      assert property (reg_wr_i && sel_pdir
                       |=> analog_out_buf_en_o == !$past(reg_wdata_i[`DACC_BIT_PINDIR]))
      else $error("Analogue pin buffer does not follow the direction bit");

   unmapped_rd_a:
      assert property (reg_rd_i && !(sel_pce || sel_mode || sel_value || sel_pdir)
                       |=> reg_rdata_o == 8'h00)
      else $error("Unmapped read returned nonzero data");

   // Main scenarios
   normal_update_c: cover property (wr_val_s ##2 conv_active_o && !realtime_mode_o);
   rt_update_c: cover property (conv_active_o && realtime_mode_o && rt_trigger_i);
   gate_off_c: cover property (conv_active_o ##1 !conv_clk_en_o);
   pin_release_c: cover property (conv_active_o && !analog_out_buf_en_o);
endmodule

// ==== pkg/dacc_conv_if.sv ====
// Purpose: Carries converter configuration from the register bank to the output stage
// Assumes: Single clock domain
// Notes: The top drives the clock gate level into it
`timescale 1ns/1ns
interface dacc_conv_if;
   import dacc_pkg::*;
   logic conv_clk_en;
   dacc_byte_type mode;
   dacc_byte_type value;

   modport bank (input conv_clk_en, output mode, output value);
   modport conv (input conv_clk_en, input mode, input value);
   modport top (output conv_clk_en, input mode, input value);
endinterface

// ==== pkg/dacc_params.svh ====
// Purpose: Offsets, field positions and reset values of the converter channel control
// Assumes: 8-bit registers on a plain strobe port, one register per address
// Notes: Definitions only
//
// Overview of operation
// [R1] Clock-enable bit 7 at 0 stops the converter's input clock.
// [R2] Clock-enable at 0 makes writes to converter registers be ignored.
// [R3] Clock-enable at 0 holds the whole converter in reset.
// [R4] Clock-enable at 1 supplies the clock and allows register reads and writes.
// [R5] Mode bit 0 selects normal mode at 0, real-time output mode at 1.
// [R6] Mode bit 4 enables conversion at 1 and stops it at 0.
// [R7] 8-bit code sets output voltage to reference times code over 256.
// [R8] Port direction bit 2 at 1 makes the analogue pin input, buffer off.
// [R9] Normal mode with conversion enabled shows a new code without any trigger.
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH

// Register offsets
`define DACC_OFS_PCE 3'h0
`define DACC_OFS_MODE 3'h1
`define DACC_OFS_VALUE 3'h2
`define DACC_OFS_PDIR 3'h3

// Field positions
`define DACC_BIT_CLKEN 7
`define DACC_BIT_MODE0 0
`define DACC_BIT_CONV0 4
`define DACC_BIT_PINDIR 2

// Implemented bits; the rest read as zero
`define DACC_PCE_MASK 8'hf9
`define DACC_MODE_MASK 8'h33

// Reset values
`define DACC_RST_PCE 8'h00
`define DACC_RST_MODE 8'h00
`define DACC_RST_VALUE 8'h00
`define DACC_RST_PDIR 8'hff
`define DACC_RST_CODE 8'h00

// Number of output steps across the reference voltage
`define DACC_CODE_STEPS 9'h100

`endif

// ==== pkg/dacc_pkg.sv ====
// Purpose: Types shared by the converter channel control modules
// Assumes: Nothing beyond the params header
// Notes: Holds types only; numbers live in the header
package dacc_pkg;

   // Output mode of channel 0
   typedef enum logic {DACC_NORMAL, DACC_REALTIME} dacc_mode_type;

   // Eight-bit register word
   typedef logic [7:0] dacc_byte_type;

endpackage

// ==== sim/dacc_tb.sv ====
// Purpose: Self-checking bench for the converter channel control top
// Assumes: Register port latencies as handed over; strobes driven right after rising edges
// Notes: Table rows cover the plain register paths; trigger, gating and reset are by hand
`timescale 1ns/1ns
`include "dacc_params.svh"
module testbench
   import dacc_pkg::*;
;
   // One table row: a write, then the outputs and read-back it should give
   typedef struct packed {
      logic [2:0] addr;
      dacc_byte_type wd;
      dacc_byte_type rd;
      logic act;
      logic rt;
      dacc_byte_type code;
      logic buf_en;
   } dacc_tb_row_type;

   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] reg_addr_i = 3'h0;
   dacc_byte_type reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic rt_trigger_i = 1'b0;
   dacc_byte_type reg_rdata_o;
   logic conv_clk_en_o;
   logic conv_active_o;
   logic realtime_mode_o;
   dacc_byte_type analog_code_o;
   dacc_byte_type port2_out_en_o;
   logic analog_out_buf_en_o;
   int fails = 0;
   int num_checks = 0;

   // Rows run in order; each leans on the state the rows before it left
   dacc_tb_row_type rows [0:8] = '{
      '{3'h0, 8'h80, 8'h80, 1'b0, 1'b0, 8'h00, 1'b0},
      '{3'h1, 8'h10, 8'h10, 1'b1, 1'b0, 8'h00, 1'b0},
      '{3'h2, 8'h40, 8'h40, 1'b1, 1'b0, 8'h40, 1'b0},
      '{3'h2, 8'hff, 8'hff, 1'b1, 1'b0, 8'hff, 1'b0},
      '{3'h1, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
      '{3'h1, 8'hff, 8'h33, 1'b1, 1'b1, 8'h00, 1'b0},
      '{3'h3, 8'hfb, 8'hfb, 1'b1, 1'b1, 8'h00, 1'b1},
      '{3'h0, 8'hff, 8'hf9, 1'b1, 1'b1, 8'h00, 1'b1},
      '{3'h5, 8'haa, 8'h00, 1'b1, 1'b1, 8'h00, 1'b1}
   };

   dacc_top dut (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o),
      .rt_trigger_i(rt_trigger_i),
      .conv_clk_en_o(conv_clk_en_o),
      .conv_active_o(conv_active_o),
      .realtime_mode_o(realtime_mode_o),
      .analog_code_o(analog_code_o),
      .port2_out_en_o(port2_out_en_o),
      .analog_out_buf_en_o(analog_out_buf_en_o)
   );

   // 100 MHz clock
   always #5 mclk_i = ~mclk_i;

   // Byte compare; case equality so an unknown never matches
   task automatic chk8(input dacc_byte_type got, input dacc_byte_type exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Single-bit compare
   task automatic chk1(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // Write cycle; one idle edge after it so a following call never re-drives the strobe at once
   task automatic wr(input logic [2:0] a, input dacc_byte_type d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   // Read cycle; data are only looked at in the single cycle where they stand
   task automatic rd(input logic [2:0] a, input dacc_byte_type exp);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk8(reg_rdata_o, exp, "read data");
      @(posedge mclk_i);
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
      chk1(conv_clk_en_o, 1'b0, "gate after reset");
      chk8(port2_out_en_o, 8'h00, "port enables after reset");
      @(posedge mclk_i);
      // Gated writes must be dropped: checked once the gate opens below
      wr(`DACC_OFS_MODE, 8'h10);
      wr(`DACC_OFS_VALUE, 8'h40);
      rd(`DACC_OFS_PDIR, 8'hff);
      rd(`DACC_OFS_PCE, 8'h00);
      // Table: write, let code settle two edges, then check outputs and read back
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wd);
         repeat (2) @(posedge mclk_i);
         #1;
         chk1(conv_clk_en_o, 1'b1, "gate level");
         chk1(conv_active_o, rows[i].act, "conversion running");
         chk1(realtime_mode_o, rows[i].rt, "realtime mode");
         chk8(analog_code_o, rows[i].code, "code");
         chk1(analog_out_buf_en_o, rows[i].buf_en, "pin buffer");
         @(posedge mclk_i);
         rd(rows[i].addr, rows[i].rd);
      end
      chk8(port2_out_en_o, 8'h04, "port enables");
      // Realtime mode: a new value waits for the trigger
      wr(`DACC_OFS_VALUE, 8'h55);
      repeat (2) @(posedge mclk_i);
      #1;
      chk8(analog_code_o, 8'h00, "code before trigger");
      @(posedge mclk_i);
      rt_trigger_i <= 1'b1;
      @(posedge mclk_i);
      rt_trigger_i <= 1'b0;
      #1;
      chk8(analog_code_o, 8'h55, "code after trigger");
      // Back to normal mode, value follows with no trigger
      @(posedge mclk_i);
      wr(`DACC_OFS_MODE, 8'h10);
      wr(`DACC_OFS_VALUE, 8'h66);
      repeat (2) @(posedge mclk_i);
      #1;
      chk8(analog_code_o, 8'h66, "code in normal mode");
      // Close the gate: converter stops, later writes are lost
      @(posedge mclk_i);
      wr(`DACC_OFS_PCE, 8'h00);
      #1;
      chk1(conv_clk_en_o, 1'b0, "gate closed");
      @(posedge mclk_i);
      wr(`DACC_OFS_VALUE, 8'h77);
      repeat (2) @(posedge mclk_i);
      #1;
      chk1(conv_active_o, 1'b0, "stopped while gated");
      chk8(analog_code_o, 8'h00, "code while gated");
      // Reopen: mode and value must come back at reset values
      @(posedge mclk_i);
      wr(`DACC_OFS_PCE, 8'h80);
      rd(`DACC_OFS_MODE, 8'h00);
      rd(`DACC_OFS_VALUE, 8'h00);
      // Reset in mid-run returns gate and pin direction to reset state
      rst_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      chk1(conv_clk_en_o, 1'b0, "gate in reset");
      chk1(analog_out_buf_en_o, 1'b0, "pin buffer in reset");
      rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(`DACC_OFS_PDIR, 8'hff);
      wrap_up();
   end
endmodule
